// ---- led_xover_pkg.sv ----
package led_xover_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] LED_SOURCE_SELECT_ADDR = 5'h17;
  localparam logic [4:0] PAIR_CROSSOVER_CONTROL_ADDR = 5'h18;

  // ---------------------------------------------------------------
  // Indicator select field layout and reset values
  // ---------------------------------------------------------------
  localparam int FIRST_SEL_LSB = 0;
  localparam int SECOND_SEL_LSB = 4;
  localparam int SEL_W = 4;
  localparam logic [3:0] FIRST_SEL_RESET = 4'h0;
  localparam logic [3:0] SECOND_SEL_RESET = 4'h1;

  // Indicator source codes
  typedef enum logic [3:0] {
    SRC_LINK_GOOD = 4'h0,
    SRC_ANY_ACT = 4'h1,
    SRC_TX_ACT = 4'h2,
    SRC_RX_ACT = 4'h3,
    SRC_COLLISION = 4'h4,
    SRC_SPEED_100 = 4'h5,
    SRC_SPEED_10 = 4'h6,
    SRC_FULL_DUPLEX = 4'h7,
    SRC_LINK_BLINK = 4'h8
  } led_src_t;

  // ---------------------------------------------------------------
  // Crossover control field layout and reset values
  // ---------------------------------------------------------------
  localparam int PD_BIT = 7;
  localparam int AUTO_PAIR_SWITCH_ENABLE_BIT = 6;
  localparam int XOVER_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int SEED_LSB = 0;
  localparam logic PD_RESET = 1'b1;
  localparam logic AUTO_PAIR_SWITCH_ENABLE_RESET = 1'b1;
  localparam logic XOVER_RESET = 1'b0;
  localparam logic [3:0] SEED_RESET = 4'h0;
  localparam logic [3:0] SEED_NONE = 4'h0;
  localparam logic [3:0] SEED_INTERNAL = 4'h5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int LED_STRETCH_MS = 50;
  localparam int LED_STRETCH_CYCLES = (CLK_HZ / 1000) * LED_STRETCH_MS;

endpackage

// ---- indicator_drive.sv ----
`timescale 1ns/1ps
module indicator_drive
  import led_xover_pkg::*;
#(
  parameter int STRETCH_CYCLES = LED_STRETCH_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] sel,
  input wire logic link_good,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  output logic led_on_q
);

  localparam int CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(STRETCH_CYCLES);
  localparam logic [CW-1:0] CNT_HALF = CW'(STRETCH_CYCLES / 2);

  logic [CW-1:0] any_cnt_q, any_cnt_d;
  logic [CW-1:0] tx_cnt_q, tx_cnt_d;
  logic [CW-1:0] rx_cnt_q, rx_cnt_d;
  logic [CW-1:0] col_cnt_q, col_cnt_d;
  logic led_on_d;

  // ---------------------------------------------------------------
  // Pulse stretchers
  // ---------------------------------------------------------------
  // Short frames would flash for microseconds; hold them visible
  always_comb begin
    any_cnt_d = any_cnt_q;
    tx_cnt_d = tx_cnt_q;
    rx_cnt_d = rx_cnt_q;
    col_cnt_d = col_cnt_q;
    if (rx_act || tx_act) any_cnt_d = CNT_LOAD;
    else if (any_cnt_q != '0) any_cnt_d = any_cnt_q - CW'(1);
    if (tx_act) tx_cnt_d = CNT_LOAD;
    else if (tx_cnt_q != '0) tx_cnt_d = tx_cnt_q - CW'(1);
    if (rx_act) rx_cnt_d = CNT_LOAD;
    else if (rx_cnt_q != '0) rx_cnt_d = rx_cnt_q - CW'(1);
    if (collision) col_cnt_d = CNT_LOAD;
    else if (col_cnt_q != '0) col_cnt_d = col_cnt_q - CW'(1);
  end

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  // Unused codes keep the indicator dark
  always_comb begin
    case (sel)
      SRC_LINK_GOOD: led_on_d = link_good;
      SRC_ANY_ACT: led_on_d = (any_cnt_q != '0);
      SRC_TX_ACT: led_on_d = (tx_cnt_q != '0);
      SRC_RX_ACT: led_on_d = (rx_cnt_q != '0);
      SRC_COLLISION: led_on_d = (col_cnt_q != '0);
      SRC_SPEED_100: led_on_d = link_good && speed_100;
      SRC_SPEED_10: led_on_d = link_good && !speed_100;
      SRC_FULL_DUPLEX: led_on_d = full_duplex;
      // Dark for the first half of each stretch, lit otherwise while link is good
      SRC_LINK_BLINK: led_on_d = link_good && (any_cnt_q <= CNT_HALF);
      default: led_on_d = 1'b0;
    endcase
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      any_cnt_q <= '0;
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
      col_cnt_q <= '0;
      led_on_q <= 1'b0;
    end else begin
      any_cnt_q <= any_cnt_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      col_cnt_q <= col_cnt_d;
      led_on_q <= led_on_d;
    end
  end

endmodule // indicator_drive

// ---- led_select_and_crossover_ctrl.sv ----
`timescale 1ns/1ps
module led_select_and_crossover_ctrl
  import led_xover_pkg::*;
#(
  parameter int STRETCH_CYCLES = LED_STRETCH_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  // Management register port, from the serial management decoder
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Link condition inputs from the PHY core
  input wire logic link_good,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic collision,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic aneg_enabled,
  input wire logic partner_negotiating,
  // Pair switching engine status
  input wire logic engine_crossed,
  input wire logic engine_done,
  // Indicator outputs, high lights the LED
  output logic first_led_q,
  output logic second_led_q,
  // Crossover control to the pair switching engine
  output logic switch_run_q,
  output logic [3:0] switch_seed_q,
  output logic pair_crossed_q
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [3:0] first_indicator_select_q, first_indicator_select_d;
  logic [3:0] second_indicator_select_q, second_indicator_select_d;
  logic parallel_detect_enable_q, parallel_detect_enable_d;
  logic auto_pair_switch_enable_q, auto_pair_switch_enable_d;
  logic forced_crossover_q, forced_crossover_d;
  logic [3:0] crossover_seed_q, crossover_seed_d;
  logic wr_led, wr_xover;

  assign wr_led = reg_wr && (reg_addr == LED_SOURCE_SELECT_ADDR);
  assign wr_xover = reg_wr && (reg_addr == PAIR_CROSSOVER_CONTROL_ADDR);

  // Next register values from management writes
  always_comb begin
    first_indicator_select_d = first_indicator_select_q;
    second_indicator_select_d = second_indicator_select_q;
    parallel_detect_enable_d = parallel_detect_enable_q;
    auto_pair_switch_enable_d = auto_pair_switch_enable_q;
    forced_crossover_d = forced_crossover_q;
    crossover_seed_d = crossover_seed_q;
    if (wr_led) begin
      // Upper byte is expected zero and simply not stored
      first_indicator_select_d =
        reg_wdata[FIRST_SEL_LSB +: SEL_W];
      second_indicator_select_d = reg_wdata[SECOND_SEL_LSB +: SEL_W];
    end
    if (wr_xover) begin
      parallel_detect_enable_d = reg_wdata[PD_BIT];
      auto_pair_switch_enable_d = reg_wdata[AUTO_PAIR_SWITCH_ENABLE_BIT];
      // Forcing only takes when the same write leaves auto off
      if (!reg_wdata[AUTO_PAIR_SWITCH_ENABLE_BIT]) begin
        forced_crossover_d = reg_wdata[XOVER_BIT];
      end
      crossover_seed_d = reg_wdata[SEED_LSB +: 4];
    end
  end

  // Register the configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      first_indicator_select_q <= FIRST_SEL_RESET;
      second_indicator_select_q <= SECOND_SEL_RESET;
      parallel_detect_enable_q <= PD_RESET;
      auto_pair_switch_enable_q <= AUTO_PAIR_SWITCH_ENABLE_RESET;
      forced_crossover_q <= XOVER_RESET;
      crossover_seed_q <= SEED_RESET;
    end else begin
      first_indicator_select_q <= first_indicator_select_d;
      second_indicator_select_q <= second_indicator_select_d;
      parallel_detect_enable_q <= parallel_detect_enable_d;
      auto_pair_switch_enable_q <= auto_pair_switch_enable_d;
      forced_crossover_q <= forced_crossover_d;
      crossover_seed_q <= crossover_seed_d;
    end
  end

  // ---------------------------------------------------------------
  // Crossover control
  // ---------------------------------------------------------------
  logic switch_run_d;
  logic [3:0] switch_seed_d;
  logic pair_crossed_d;
  logic crossover_state;
  logic crossover_sequence_done;

  // With auto on, switching runs with local negotiation on, or off with
  // partner negotiating when parallel detect is allowed
  always_comb begin
    switch_run_d = auto_pair_switch_enable_q &&
      (aneg_enabled ||
       (parallel_detect_enable_q && partner_negotiating));
    // A zero seed would stall the algorithm, so substitute one
    switch_seed_d = (crossover_seed_q == SEED_NONE) ?
      SEED_INTERNAL : crossover_seed_q;
    // Engine decides under auto, the forced bit decides otherwise
    pair_crossed_d = auto_pair_switch_enable_q ?
      engine_crossed : forced_crossover_q;
  end

  // Readback view of pair state and completion
  assign crossover_state = pair_crossed_q;
  assign crossover_sequence_done =
    auto_pair_switch_enable_q && engine_done;

  // Register the engine controls
  always_ff @(posedge clk) begin
    if (srst) begin
      switch_run_q <= 1'b0;
      switch_seed_q <= SEED_INTERNAL;
      pair_crossed_q <= XOVER_RESET;
    end else begin
      switch_run_q <= switch_run_d;
      switch_seed_q <= switch_seed_d;
      pair_crossed_q <= pair_crossed_d;
    end
  end

  // ---------------------------------------------------------------
  // Register readback
  // ---------------------------------------------------------------
  logic [15:0] reg_rdata_d;
  logic reg_rvalid_d;

  // Unmapped addresses read zero; reserved bytes always zero
  // Read data holds until the next read
  always_comb begin
    reg_rdata_d = reg_rdata_q;
    reg_rvalid_d = reg_rd;
    if (reg_rd) begin
      reg_rdata_d = 16'h0000;
      case (reg_addr)
        LED_SOURCE_SELECT_ADDR: begin
          reg_rdata_d[FIRST_SEL_LSB +: SEL_W] = first_indicator_select_q;
          reg_rdata_d[SECOND_SEL_LSB +: SEL_W] = second_indicator_select_q;
        end
        PAIR_CROSSOVER_CONTROL_ADDR: begin
          reg_rdata_d[PD_BIT] = parallel_detect_enable_q;
          reg_rdata_d[AUTO_PAIR_SWITCH_ENABLE_BIT] = auto_pair_switch_enable_q;
          reg_rdata_d[XOVER_BIT] = crossover_state;
          reg_rdata_d[DONE_BIT] = crossover_sequence_done;
          reg_rdata_d[SEED_LSB +: 4] = crossover_seed_q;
        end
        default: reg_rdata_d = 16'h0000;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_q <= 16'h0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q <= reg_rdata_d;
      reg_rvalid_q <= reg_rvalid_d;
    end
  end

  // ---------------------------------------------------------------
  // Indicator drivers
  // ---------------------------------------------------------------
  // One driver per indicator, each with its own stretchers
  indicator_drive #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
  ) u_first_led (
    .clk(clk),
    .srst(srst),
    .sel(first_indicator_select_q),
    .link_good(link_good),
    .rx_act(rx_act),
    .tx_act(tx_act),
    .collision(collision),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .led_on_q(first_led_q)
  );

  indicator_drive #(
    .STRETCH_CYCLES(STRETCH_CYCLES)
  ) u_second_led (
    .clk(clk),
    .srst(srst),
    .sel(second_indicator_select_q),
    .link_good(link_good),
    .rx_act(rx_act),
    .tx_act(tx_act),
    .collision(collision),
    .speed_100(speed_100),
    .full_duplex(full_duplex),
    .led_on_q(second_led_q)
  );

endmodule // led_select_and_crossover_ctrl

// ---- led_xover_chk.sv ----
`timescale 1ns/1ps
module led_xover_chk
  import led_xover_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic aneg_enabled,
  input wire logic partner_negotiating,
  input wire logic engine_crossed,
  input wire logic engine_done,
  input wire logic first_led_q,
  input wire logic switch_run_q,
  input wire logic [3:0] switch_seed_q,
  input wire logic pair_crossed_q
);
  // ---------------------------------------------------------------
  // Shadow of the host-written fields
  // ---------------------------------------------------------------
  logic [7:0] led_q;
  logic [7:0] xc_q;
  logic [1:0] up_q;
  logic want;
  logic [3:0] eff;
  logic spd;
  // Forced bit only moves on a write that turns auto off
  always_ff @(posedge clk) begin
    up_q <= srst ? 2'b00 : {up_q[0], 1'b1};
    if (srst) begin
      led_q <= 8'h10;
      xc_q <= 8'hc0;
    end else if (reg_wr && reg_addr == LED_SOURCE_SELECT_ADDR) begin
      led_q <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == PAIR_CROSSOVER_CONTROL_ADDR) begin
      xc_q <= {reg_wdata[7:6], reg_wdata[6] ? xc_q[5] : reg_wdata[5],
               1'b0, reg_wdata[3:0]};
    end
  end
  // Expected values, judged one cycle late
  assign want = xc_q[6] && (aneg_enabled || xc_q[7] && partner_negotiating);
  assign eff = (xc_q[3:0] == 4'h0) ? 4'h5 : xc_q[3:0];
  assign spd = link_good && speed_100;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_upper_read_zero: assert property (
    reg_rvalid_q |-> reg_rdata_q[15:8] == 8'h00)
    else $error("upper read bits not zero");
  chk_done_gated: assert property (
    reg_rd && reg_addr == PAIR_CROSSOVER_CONTROL_ADDR &&
    (!engine_done || !xc_q[6]) |=> !reg_rdata_q[4])
    else $error("done bit set without finished sequence");
  chk_run_gate: assert property (
    up_q[1] |-> switch_run_q == $past(want))
    else $error("switch run does not follow auto and detect");
  chk_seed_subst: assert property (
    up_q[1] |-> switch_seed_q == $past(eff))
    else $error("effective seed wrong");
  chk_pair_auto: assert property (
    switch_run_q |-> pair_crossed_q == $past(engine_crossed))
    else $error("pair does not follow engine");
  chk_pair_forced: assert property (
    up_q[1] && !$past(xc_q[6]) |-> pair_crossed_q == $past(xc_q[5]))
    else $error("forced pair not applied");
  chk_led_link: assert property (
    up_q[1] && $past(led_q[3:0]) == 4'h0 |-> first_led_q == $past(link_good))
    else $error("link indicator wrong");
  chk_led_speed: assert property (
    up_q[1] && $past(led_q[3:0]) == 4'h5 |-> first_led_q == $past(spd))
    else $error("speed indicator wrong");
  cover property (reg_rvalid_q && reg_rdata_q[4]);
  cover property (pair_crossed_q && !switch_run_q);
  cover property (first_led_q && led_q[3:0] == 4'h8);
endmodule // led_xover_chk

bind led_select_and_crossover_ctrl led_xover_chk i_led_xover_chk (.*);

// ---- pair_engine_model.sv ----
`timescale 1ns/1ps
module pair_engine_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [3:0] seed,
  output logic crossed,
  output logic done
);
  logic [2:0] cnt_q;
  // Hunts four cycles, restarting whenever the run grant drops
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_q <= 3'h0;
    end else if (cnt_q != 3'h4) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Toggles while hunting so a stale pair value is visible
  assign done = (cnt_q == 3'h4);
  assign crossed = done ? seed[0] : cnt_q[0];
endmodule // pair_engine_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
  import led_xover_pkg::*;
;
  localparam logic [4:0] LA = LED_SOURCE_SELECT_ADDR;
  localparam logic [4:0] XC = PAIR_CROSSOVER_CONTROL_ADDR;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata_q;
  logic reg_rvalid_q;
  logic link_good = 1'b1;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  logic collision = 1'b0;
  logic speed_100 = 1'b1;
  logic full_duplex = 1'b0;
  logic aneg_enabled = 1'b0;
  logic partner_negotiating = 1'b0;
  logic engine_crossed;
  logic engine_done;
  logic first_led_q;
  logic second_led_q;
  logic switch_run_q;
  logic [3:0] switch_seed_q;
  logic pair_crossed_q;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  // Lit codes per input set: link+100, link+10+full, link down+full
  logic [8:0] lit [3] = '{9'h121, 9'h1c1, 9'h080};

  always #50 clk = ~clk;
  // Short stretch keeps the activity cases to a few cycles
  led_select_and_crossover_ctrl #(.STRETCH_CYCLES(8))
    i_led_select_and_crossover_ctrl (.*);
  pair_engine_model i_pair_engine_model (
    .clk(clk),
    .srst(srst),
    .run(switch_run_q),
    .seed(switch_seed_q),
    .crossed(engine_crossed),
    .done(engine_done)
  );

  // ---------------------------------------------------------------
  // Access and reporting tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands one cycle after the strobe edge
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({15'h0000, reg_rvalid_q}, 16'h0001);
    check(reg_rdata_q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input bit tx);
    @(posedge clk);
    rx_act <= !tx;
    tx_act <= tx;
    @(posedge clk);
    rx_act <= 1'b0;
    tx_act <= 1'b0;
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk(LA, 16'h0010);
    rd_chk(XC, 16'h00c0);
    rd_chk(5'h19, 16'h0000);
    wr(XC, 16'hffd3);
    rd_chk(XC, 16'h00c3);
    check({12'h000, switch_seed_q}, 16'h0003);
    @(posedge clk);
    partner_negotiating <= 1'b1;
    idle(12);
    check({15'h0000, switch_run_q}, 16'h0001);
    rd_chk(XC, 16'h00f3);
    wr(XC, 16'h0043);
    idle(3);
    check({15'h0000, switch_run_q}, 16'h0000);
    rd_chk(XC, 16'h0043);
    @(posedge clk);
    aneg_enabled <= 1'b1;
    wr(XC, 16'h00c0);
    idle(12);
    check({12'h000, switch_seed_q}, 16'h0005);
    rd_chk(XC, 16'h00f0);
    wr(XC, 16'h0020);
    idle(2);
    check({15'h0000, pair_crossed_q}, 16'h0001);
    rd_chk(XC, 16'h0020);
    // Crossed bit written while auto is on must not stick
    wr(XC, 16'h00e2);
    idle(8);
    rd_chk(XC, 16'h00d2);
    wr(XC, 16'h0000);
    idle(1);
    rd_chk(XC, 16'h0000);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      link_good <= (s != 2);
      speed_100 <= (s == 0);
      full_duplex <= (s != 0);
      for (int c = 0; c < 9; c++) begin
        wr(LA, {8'h00, c[3:0], c[3:0]});
        idle(2);
        check({14'h0000, second_led_q, first_led_q},
              {14'h0000, {2{lit[s][c]}}});
      end
    end
    @(posedge clk);
    link_good <= 1'b1;
    wr(LA, 16'h0023);
    pulse(1'b0);
    idle(2);
    check({14'h0000, second_led_q, first_led_q}, 16'h0001);
    idle(10);
    check({14'h0000, second_led_q, first_led_q}, 16'h0000);
    wr(LA, 16'h0008);
    pulse(1'b1);
    idle(2);
    check({15'h0000, first_led_q}, 16'h0000);
    idle(10);
    check({15'h0000, first_led_q}, 16'h0001);
    // Collision must light only its own code, any activity the other
    wr(LA, 16'h0041);
    @(posedge clk);
    collision <= 1'b1;
    @(posedge clk);
    collision <= 1'b0;
    idle(2);
    check({14'h0000, second_led_q, first_led_q}, 16'h0002);
    idle(10);
    pulse(1'b1);
    idle(2);
    check({14'h0000, second_led_q, first_led_q}, 16'h0001);
    give_verdict();
  end
endmodule // testbench
